// >>> core/srsp_pkg.sv
/*
  Shared constants for the serial ROM read port: command codes,
  field widths, bit counts and the link clock divider.
  Assumes both ends import it; the interface does not.
*/
package srsp_pkg;
  // ****************************************
  // Commands and fields
  // ****************************************
  localparam logic [7:0] SRSP_CMD_READ = 8'h03;
  localparam logic [7:0] SRSP_CMD_FAST = 8'h0b;
  localparam int SRSP_ADDR_BITS = 24;
  localparam int SRSP_ARRAY_BITS = 23;
  localparam int SRSP_CMD_BITS = 8;
  localparam int SRSP_DUMMY_BITS = 8;
  localparam int SRSP_CNT_W = 6;
  // ****************************************
  // Timing and FIFO depth
  // ****************************************
  localparam int SRSP_CLK_NS = 50;
  localparam int SRSP_SCK_NS = 400;
  localparam int SRSP_HALF_CYC = SRSP_SCK_NS / (2 * SRSP_CLK_NS);
  localparam int SRSP_FIFO_DEPTH = 4;
endpackage

// >>> core/srsp_if.sv
/*
  Four-wire serial link plus pause line between the master and the ROM.
  Resolves the data-out pin from its enable here, low when not enabled.
*/
interface srsp_if;
  logic sck;
  logic mosi;
  logic cs_n;
  logic hold_n;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // Pull-down when floated
  assign miso = miso_oe ? miso_o : 1'b0;
  modport rom (input sck, input mosi, input cs_n, input hold_n, output miso_o, output miso_oe);
  modport master (output sck, output mosi, output cs_n, output hold_n, input miso);
endinterface

// >>> core/srsp_fifo.sv
/*
  Small valid/ready FIFO.
  Assumes one clock and an active-high asynchronous reset.
*/
module srsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] cnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
  } srsp_fifo_st_t;
  srsp_fifo_st_t s_r, s_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic push;
  logic pop;

  // Handshakes
  assign in_ready = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = mem_r[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer update
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Storage
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_r[s_r.wp] <= in_data;
    end
  end
endmodule

// >>> core/srsp_rom.sv
/*
  ROM end of the serial link: decodes read commands, streams array bytes.
  Assumes link pins are asynchronous to clock and sampled twice here.
*/
// What this block does
// R1: Output bit changes on clock falling edge
// R2: Capture input bits on clock rising edge
// R3: Deselected ignores bus; select means active
// R4: Decode only after a select falling edge
// R5: Deselect returns to standby when idle
// R6: Pause only while selected
// R7: Pause starts when clock low
// R8: Pause ends when clock low
// R9: Paused: float output, freeze all state
// R10: Deselect while paused resets logic
// R11: Everything most significant bit first
// R12: First rising edge takes command bit
// R13: Read 03h: address then data
// R14: Fast read 0Bh: address, dummy, data
// R15: Deselect ends read, output floats
// R16: Top address bit ignored
// R17: Array of eight mebibytes, bytes
// R18: Idle clock low or high both work
// R19: Address increments per byte, wraps
// R20: Unknown command floats and ignores
module srsp_rom
  import srsp_pkg::*;
#(
  parameter int ARRAY_BITS = SRSP_ARRAY_BITS
) (
  input wire logic clock,
  input wire logic rst,
  srsp_if.rom link,
  output logic active,
  output logic [ARRAY_BITS-1:0] rd_addr,
  output logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  import srsp_pkg::*;

  typedef enum logic [2:0] {ST_OFF, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGN} srsp_st_t;
  typedef struct packed {
    logic [1:0] sck_s;
    logic [1:0] cs_s;
    logic [1:0] hold_s;
    logic [1:0] mosi_s;
    logic sck_d;
    logic cs_d;
    logic armed;
    logic paused;
    srsp_st_t st;
    logic [SRSP_CNT_W-1:0] cnt;
    logic [SRSP_ADDR_BITS-1:0] sh;
    logic fast;
    logic [ARRAY_BITS-1:0] addr;
    logic [7:0] obyte;
    logic [7:0] nbyte;
    logic req;
    logic q;
    logic oe;
    logic act;
  } srsp_rom_st_t;
  srsp_rom_st_t s_r, s_nxt;

  logic sck, cs_n, hold_n, mosi, rise, fall, cs_fall, dsel;
  assign sck = s_r.sck_s[1];
  assign cs_n = s_r.cs_s[1];
  assign hold_n = s_r.hold_s[1];
  assign mosi = s_r.mosi_s[1];
  assign rise = sck && !s_r.sck_d;
  assign fall = !sck && s_r.sck_d;
  assign cs_fall = !cs_n && s_r.cs_d;
  assign dsel = cs_n && !s_r.cs_d;

  // Outputs straight from flops
  assign link.miso_o = s_r.q;
  assign link.miso_oe = s_r.oe;
  assign active = s_r.act;
  assign rd_addr = s_r.addr;
  assign rd_req = s_r.req;

  // Link decode
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sck_s = {s_r.sck_s[0], link.sck};
    s_nxt.cs_s = {s_r.cs_s[0], link.cs_n};
    s_nxt.hold_s = {s_r.hold_s[0], link.hold_n};
    s_nxt.mosi_s = {s_r.mosi_s[0], link.mosi};
    s_nxt.sck_d = sck;
    s_nxt.cs_d = cs_n;
    s_nxt.req = 1'b0;
    if (rd_valid)
    begin
      s_nxt.nbyte = rd_data;
    end
    // Pause enter and leave only with clock low
    if (!cs_n && !sck) // R6 R7 R8
    begin
      s_nxt.paused = !hold_n;
    end
    if (cs_n)
    begin
      // Deselect, also from pause, resets the logic
      s_nxt.st = ST_OFF; // R3 R10 R15
      s_nxt.paused = 1'b0;
      s_nxt.oe = 1'b0;
      s_nxt.act = 1'b0; // R5
      s_nxt.cnt = '0;
    end
    else if (cs_fall)
    begin
      s_nxt.armed = 1'b1; // R4
      s_nxt.act = 1'b1; // R3
      s_nxt.st = ST_CMD; // R12
      s_nxt.cnt = '0;
      s_nxt.oe = 1'b0;
    end
    else if (s_r.paused || (!hold_n && !sck))
    begin
      s_nxt.oe = 1'b0; // R9
    end
    else if (s_r.armed)
    begin
      if (s_r.st == ST_DATA && !s_r.oe)
      begin
        s_nxt.oe = 1'b1;
      end
      if (rise) // R2 R18
      begin
        s_nxt.sh = {s_r.sh[SRSP_ADDR_BITS-2:0], mosi}; // R11
        s_nxt.cnt = s_r.cnt + 1'b1;
        case (s_r.st)
          ST_CMD:
          begin
            if (s_r.cnt == SRSP_CNT_W'(SRSP_CMD_BITS - 1))
            begin
              s_nxt.cnt = '0;
              s_nxt.fast = {s_r.sh[6:0], mosi} == SRSP_CMD_FAST; // R14
              if ({s_r.sh[6:0], mosi} == SRSP_CMD_READ || {s_r.sh[6:0], mosi} == SRSP_CMD_FAST)
              begin
                s_nxt.st = ST_ADDR; // R13
              end
              else
              begin
                s_nxt.st = ST_IGN; // R20
              end
            end
          end
          ST_ADDR:
          begin
            if (s_r.cnt == SRSP_CNT_W'(SRSP_ADDR_BITS - 1))
            begin
              s_nxt.cnt = '0;
              s_nxt.addr = {s_r.sh[ARRAY_BITS-2:0], mosi}; // R16 R17
              s_nxt.req = 1'b1;
              s_nxt.st = s_r.fast ? ST_DUMMY : ST_DATA;
            end
          end
          ST_DUMMY:
          begin
            if (s_r.cnt == SRSP_CNT_W'(SRSP_DUMMY_BITS - 1))
            begin
              s_nxt.cnt = '0;
              s_nxt.st = ST_DATA;
            end
          end
          ST_DATA:
          begin
            s_nxt.cnt = s_r.cnt;
          end
          ST_IGN:
          begin
            s_nxt.cnt = '0;
          end
          default:
          begin
            s_nxt.st = ST_OFF;
          end
        endcase
      end
      if (fall && s_r.st == ST_DATA) // R1
      begin
        s_nxt.oe = 1'b1;
        if (s_r.cnt[2:0] == 3'h0)
        begin
          s_nxt.q = s_r.nbyte[7]; // R11
          s_nxt.obyte = {s_r.nbyte[6:0], 1'b0};
          s_nxt.addr = s_r.addr + 1'b1; // R19
          s_nxt.req = 1'b1;
        end
        else
        begin
          s_nxt.q = s_r.obyte[7];
          s_nxt.obyte = {s_r.obyte[6:0], 1'b0};
        end
        s_nxt.cnt = {3'h0, s_r.cnt[2:0] + 3'h1};
      end
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '{sck_s: 2'h0, cs_s: 2'h3, hold_s: 2'h3, mosi_s: 2'h0, sck_d: 1'b0, cs_d: 1'b1,
               armed: 1'b0, paused: 1'b0, st: ST_OFF, cnt: '0, sh: '0, fast: 1'b0,
               addr: '0, obyte: 8'h00, nbyte: 8'h00, req: 1'b0, q: 1'b0,
               oe: 1'b0, act: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule

// >>> core/srsp_master.sv
/*
  Master end: takes a read command, clocks it out, pushes returned bytes
  into a FIFO that the user drains. Stalls the link clock while full, in the data phase only.
  Assumes user inputs are on clock.
*/
module srsp_master
  import srsp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  srsp_if.master link,
  input wire logic start,
  input wire logic fast,
  input wire logic cpol,
  input wire logic [23:0] addr,
  input wire logic [15:0] nbytes,
  input wire logic pause,
  output logic busy,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data
);
  import srsp_pkg::*;
  typedef struct packed {
    logic [1:0] miso_s;
    logic [39:0] sh;
    logic [6:0] nbits;
    logic [15:0] left;
    logic [2:0] bcnt;
    logic [7:0] rx;
    logic push;
    logic [7:0] div;
    logic phase;
    logic sck;
    logic cs_n;
    logic hold_n;
    logic busy;
    logic pol;
  } srsp_m_st_t;
  srsp_m_st_t s_r, s_nxt;
  logic in_ready;
  logic tick;
  logic [7:0] cmd;

  srsp_fifo #(.WIDTH(8), .DEPTH(SRSP_FIFO_DEPTH)) u_fifo (
    .clock(clock), .rst(rst), .in_valid(s_r.push), .in_ready(in_ready),
    .in_data(s_r.rx), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

  assign link.sck = s_r.sck;
  assign link.mosi = s_r.sh[39];
  assign link.cs_n = s_r.cs_n;
  assign link.hold_n = s_r.hold_n;
  assign busy = s_r.busy;
  assign tick = s_r.div == 8'(SRSP_HALF_CYC - 1);
  assign cmd = fast ? SRSP_CMD_FAST : SRSP_CMD_READ;

  // Sequencer
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.miso_s = {s_r.miso_s[0], link.miso};
    s_nxt.push = 1'b0;
    s_nxt.hold_n = !(pause && !s_r.cs_n);
    s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
    if (!s_r.busy)
    begin
      s_nxt.sck = cpol;
      s_nxt.pol = cpol;
      if (start && nbytes != 16'h0000)
      begin
        s_nxt.busy = 1'b1;
        s_nxt.cs_n = 1'b0;
        // Idle-high clock: first fall is a dummy shift, so lead bit is doubled
        s_nxt.sh = cpol ? {cmd[7], cmd, addr, 7'h00} : {cmd, addr, 8'h00};
        s_nxt.nbits = (fast ? 7'd40 : 7'd32) + {6'h00, cpol};
        s_nxt.left = nbytes;
        s_nxt.bcnt = 3'h0;
        s_nxt.phase = cpol;
        s_nxt.div = 8'h00;
      end
    end
    else if (tick && s_r.hold_n && !pause && (in_ready || s_r.nbits != 7'd0))
    begin
      s_nxt.phase = !s_r.phase;
      if (!s_r.phase)
      begin
        // Rising edge: device samples the command bit
        s_nxt.sck = 1'b1;
      end
      else
      begin
        // End of high half: returned bit has cleared the sync flops
        if (s_r.nbits == 7'd0)
        begin
          s_nxt.rx = {s_r.rx[6:0], s_r.miso_s[1]};
          s_nxt.bcnt = s_r.bcnt + 3'h1;
          if (s_r.bcnt == 3'h7)
          begin
            s_nxt.push = 1'b1;
            s_nxt.left = s_r.left - 16'h0001;
          end
        end
        if (s_r.nbits == 7'd0 && s_r.bcnt == 3'h7 && s_r.left == 16'h0001)
        begin
          s_nxt.cs_n = 1'b1;
          s_nxt.busy = 1'b0;
          s_nxt.sck = s_r.pol;
        end
        else
        begin
          // Falling edge: next command bit
          s_nxt.sck = 1'b0;
          if (s_r.nbits != 7'd0)
          begin
            s_nxt.nbits = s_r.nbits - 7'd1;
            s_nxt.sh = {s_r.sh[38:0], 1'b0};
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '{miso_s: 2'h0, sh: '0, nbits: 7'd0, left: 16'h0000, bcnt: 3'h0, rx: 8'h00,
               push: 1'b0, div: 8'h00, phase: 1'b0, sck: 1'b0, cs_n: 1'b1, hold_n: 1'b1,
               busy: 1'b0, pol: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end
endmodule

// >>> test/srsp_properties.sv
/*
  Link checker for the serial ROM read port.
  Assumes the bench places it beside the link interface.
*/
module srsp_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic sck,
  input wire logic mosi,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ****
  // Helpers
  // ****
  logic sck_q;
  logic [5:0] cnt;
  logic rise;
  assign rise = sck && !sck_q;
  // Link clock rises since select fell
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sck_q <= 1'b0;
      cnt <= 6'h00;
    end
    else
    begin
      sck_q <= sck;
      if (cs_n)
        cnt <= 6'h00;
      else if (rise && cnt != 6'h3f)
        cnt <= cnt + 6'h01;
    end
  end
  // ****
  // Properties
  // ****
  sequence s_paused;
    (!hold_n && !sck && !cs_n) [*6];
  endsequence
  property p_desel_float;
    cs_n [*6] |-> !miso_oe;
  endproperty
  property p_miso_fall;
    $changed(miso_o) && miso_oe && $past(miso_oe)
      |-> !($past(sck) && $past(sck, 2) && $past(sck, 3) && $past(sck, 4) && $past(sck, 5));
  endproperty
  property p_hold_float;
    s_paused |-> !miso_oe;
  endproperty
  property p_hold_keep;
    s_paused ##1 (!hold_n && !cs_n) |-> $stable(miso_o);
  endproperty
  property p_cmd_bits;
    rise && !cs_n && cnt < 6'h08 && cnt != 6'h04 |-> mosi == (cnt > 6'h05);
  endproperty
  property p_data_after;
    $rose(miso_oe) |-> cnt >= 6'h20;
  endproperty
  property p_hold_sel;
    !hold_n |-> !cs_n;
  endproperty
  property p_resume;
    $fell(cs_n) |-> hold_n;
  endproperty
  property p_float_low;
    !miso_oe |-> !miso;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("output driven while deselected");
  a_miso_fall: assert property (p_miso_fall)
    else $error("output changed without a clock fall");
  a_hold_float: assert property (p_hold_float)
    else $error("output driven while paused");
  a_hold_keep: assert property (p_hold_keep)
    else $error("output moved while paused");
  a_cmd_bits: assert property (p_cmd_bits)
    else $error("command bit wrong");
  a_data_after: assert property (p_data_after)
    else $error("data before address complete");
  a_hold_sel: assert property (p_hold_sel)
    else $error("pause while deselected");
  a_resume: assert property (p_resume)
    else $error("select fell while paused");
  a_float_low: assert property (p_float_low)
    else $error("floated data line not at pull level");
endmodule

// >>> test/serial_rom_spi_read_port_tb_top.sv
/*
  Bench for the serial ROM read port: both ends, array model, checker.
  Assumes the core files compile first.
*/
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module serial_rom_spi_read_port_tb_top
  import srsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic fast = 1'b0;
  logic cpol = 1'b0;
  logic pause = 1'b0;
  logic out_ready = 1'b0;
  logic stall = 1'b0;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [23:0] addr = 24'h000000;
  logic [15:0] nbytes = 16'h0001;
  logic busy, out_valid, active, rd_req;
  logic [7:0] out_data, exp_b;
  logic [SRSP_ARRAY_BITS-1:0] rd_addr;
  logic [7:0] exp_q[$];
  integer errors = 0;
  integer checked = 0;
  integer seed = 41;
  integer cycles = 0;
  srsp_if srsp_if_i ();
  srsp_rom srsp_rom_i (.clock(clock), .rst(rst), .link(srsp_if_i), .active(active),
    .rd_addr(rd_addr), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));
  srsp_master srsp_master_i (.clock(clock), .rst(rst), .link(srsp_if_i), .start(start),
    .fast(fast), .cpol(cpol), .addr(addr), .nbytes(nbytes), .pause(pause), .busy(busy),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  srsp_properties srsp_properties_i (.clock(clock), .rst(rst), .sck(srsp_if_i.sck),
    .mosi(srsp_if_i.mosi), .cs_n(srsp_if_i.cs_n), .hold_n(srsp_if_i.hold_n),
    .miso_o(srsp_if_i.miso_o), .miso_oe(srsp_if_i.miso_oe), .miso(srsp_if_i.miso));
  // Array content pattern
  function automatic logic [7:0] val(input logic [22:0] a);
    return a[7:0] ^ a[15:8] ^ {1'b0, a[22:16]};
  endfunction
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One read transfer, expectations noted first
  task automatic run(input logic [23:0] a, input logic f, input logic c, input int n,
    input bit p);
    for (int i = 0; i < n; i++)
      exp_q.push_back(val(a[22:0] + 23'(i)));
    // Idle clock level settles before select falls
    cpol = c;
    wait_n(1);
    start = 1'b1;
    addr = a;
    fast = f;
    nbytes = 16'(n);
    wait_n(1);
    start = 1'b0;
    while (srsp_if_i.cs_n !== 1'b0)
      wait_n(1);
    wait_n(6);
    `CHK("active", 1'b1, active)
    if (p)
    begin
      wait_n(100 + {$random(seed)} % 200);
      pause = 1'b1;
      wait_n(40);
      pause = 1'b0;
    end
    while (busy !== 1'b0)
      wait_n(1);
    wait_n(8);
    `CHK("standby", 1'b0, active)
  endtask
  // Clock
  initial
  begin
    forever #(SRSP_CLK_NS / 2) clock = ~clock;
  end
  // Array answers each fetch
  always @(posedge clock)
  begin
    rd_valid <= rd_req;
    rd_data <= val(rd_addr);
  end
  // Random drain, stall and timeout
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      errors++;
      test_done;
    end
    else
    begin
      #1;
      out_ready = !stall && ($random(seed) % 4 != 0);
    end
  end
  // Compare each accepted byte with the oldest note
  always @(negedge clock)
    if (out_valid === 1'b1 && out_ready === 1'b1)
    begin
      exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      `CHK("data", exp_b, out_data)
    end
  // Main sequence
  initial
  begin
    wait_n(2);
    rst = 1'b0;
    run(24'h7ffffe, 1'b0, 1'b0, 4, 1'b0);
    run(24'hfffffe, 1'b1, 1'b1, 4, 1'b1);
    for (int k = 0; k < 10; k++)
      run(24'($random(seed)), k[0], k[1], 3 + k % 4, k % 3 == 2);
    stall = 1'b1;
    fork
      run(24'h000100, 1'b1, 1'b0, 8, 1'b0);
      begin
        wait_n(1500);
        stall = 1'b0;
      end
    join
    wait_n(20);
    `CHK("left", 0, exp_q.size())
    test_done;
  end
endmodule
